// ### oft_chk.sv
// port checker for the output terminal block
// assumes one clock, bound into every instance below
`timescale 1ns/1ps
module oft_chk #(
   parameter TICK_CYC = 4
) (
   // clock and reset
   input wire        i_ref_clk,
   input wire        i_rst,
   // apb
   input wire        i_psel,
   input wire        i_penable,
   input wire        i_pwrite,
   input wire [7:0]  i_paddr,
   input wire [31:0] o_prdata,
   input wire        o_pready,
   input wire        o_pslverr,
   // terminals
   input wire        o_transistor_out,
   input wire        o_relay1_contacts,
   input wire        o_multiplex_terminal
);
   default clocking cb @(posedge i_ref_clk); endclocking
   property p_rdy_one;
      disable iff (i_rst) o_pready |=> !o_pready;
   endproperty
   a_rdy_one: assert property (p_rdy_one) else $error("ready too long");
   property p_rdy_ws;
      disable iff (i_rst) i_psel && i_penable && !o_pready |=> o_pready;
   endproperty
   a_rdy_ws: assert property (p_rdy_ws) else $error("ready late");
   property p_setup;
      disable iff (i_rst) o_pready |-> $past(i_psel, 2) && !$past(i_penable, 2);
   endproperty
   a_setup: assert property (p_setup) else $error("ready without setup");
   property p_err;
      disable iff (i_rst) o_pslverr |-> o_pready;
   endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_rd_zero;
      disable iff (i_rst) !o_pready |-> o_prdata == 32'h0;
   endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("read data outside answer");
   property p_rd_hi;
      disable iff (i_rst) o_pready && !i_pwrite |-> o_prdata[31:16] == 16'h0;
   endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
   property p_map;
      disable iff (i_rst) o_pready && i_paddr[1:0] == 2'b00 |-> o_pslverr == (i_paddr > 8'h40);
   endproperty
   a_map: assert property (p_map) else $error("wrong error for address");
   property p_rst_out;
      i_rst |=> !(o_transistor_out || o_relay1_contacts || o_multiplex_terminal);
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("terminal set in reset");
   cover property (o_pslverr);
   cover property ($rose(o_transistor_out));
   cover property ($rose(o_multiplex_terminal));
endmodule // oft_chk
bind oft_output_terminal oft_chk #(.TICK_CYC(TICK_CYC)) u_chk (.i_ref_clk, .i_rst, .i_psel,
   .i_penable, .i_pwrite, .i_paddr, .o_prdata, .o_pready, .o_pslverr, .o_transistor_out,
   .o_relay1_contacts, .o_multiplex_terminal);

// ### oft_map.vh
// register map, field positions, reset values and timing counts
// assumes 10 MHz reference clock, apb word addressing
`ifndef OFT_MAP_VH
`define OFT_MAP_VH
`define OFT_ADDR_W          8
`define OFT_A_MUX_MODE      8'h00
`define OFT_A_PULSE_SRC     8'h04
`define OFT_A_AO1_SRC       8'h08
`define OFT_A_AO2_SRC       8'h0c
`define OFT_A_PULSE_FMAX    8'h10
`define OFT_A_AO1_OFS       8'h14
`define OFT_A_AO1_GAIN      8'h18
`define OFT_A_AO2_OFS       8'h1c
`define OFT_A_AO2_GAIN      8'h20
`define OFT_A_TR_DLY        8'h24
`define OFT_A_RL1_DLY       8'h28
`define OFT_A_RL2_DLY       8'h2c
`define OFT_A_RSVD_DLY      8'h30
`define OFT_A_MSW_DLY       8'h34
`define OFT_A_POLARITY      8'h38
`define OFT_A_FUNC_SEL      8'h3c
`define OFT_A_STATUS        8'h40
`define OFT_RST_AO2_SRC     16'h0001
`define OFT_RST_FMAX        16'h1388
`define OFT_RST_GAIN        16'h0064
`define OFT_FMAX_MIN        16'h0001
`define OFT_FMAX_MAX        16'h2710
`define OFT_GAIN_LIM        16'h03e8
`define OFT_OFS_LIM         16'h03e8
`define OFT_DLY_MAX         16'h8ca0
`define OFT_CLK_HZ          10000000
`define OFT_DLY_TICK_S_DIV  10
`define OFT_TICK_CYC        (`OFT_CLK_HZ / `OFT_DLY_TICK_S_DIV)
`define OFT_FN_TIMING       6'h1e
`define OFT_FN_AIN_LIM      6'h1f
`define OFT_FN_LOAD_LOST    6'h20
`define OFT_FN_REVERSE      6'h21
`define OFT_FN_TEMP         6'h23
`define OFT_FN_LOW_LIM      6'h25
`define OFT_FN_WARN         6'h26
`define OFT_FN_RUNTIME      6'h28
`define OFT_SPAN_FULL       16'h03e8
`define OFT_AO_FULL         12'hfff
`endif

// ### oft_meter.sv
// far-side pulse counter wired to the multiplexed terminal
// assumes a registered terminal level on the bench clock
`timescale 1ns/1ps
module oft_meter (
   // clock and control
   input  wire        i_ref_clk,
   input  wire        i_clr,
   // terminal and count
   input  wire        i_terminal,
   output reg  [15:0] o_edges
);
   reg last_r;
   always @(posedge i_ref_clk) begin
      last_r <= i_terminal;
      if (i_clr)
         o_edges <= 16'h0000;
      else if (i_terminal && !last_r)
         o_edges <= o_edges + 16'h0001;
   end
endmodule // oft_meter

// ### oft_output_terminal.v
// output terminal logic: status routing, delay, polarity, pulse and analog scaling
// assumes one 10 MHz clock, apb master, status inputs synchronous to the clock
// Summary of operation
// - code 30 asserts when run time reaches set time
// - code 31 asserts when input one outside limits
// - code 32 asserts in load-lost state
// - code 33 asserts while running reverse
// - code 35 asserts when heatsink reaches threshold
// - code 37 asserts at lower limit or stopped
// - code 38 warns on fault with keep-running
// - code 40 asserts when run time exceeds threshold
// - mode 0 pulse output, mode 1 switch
// - pulse output never above 100 kHz
// - pulse maps 0.01 kHz up to settable maximum
// - maximum defaults 50.00 kHz, pulse mode only
// - sources 0,1 scale to maximum output frequency
// - sources 2,3,4 scale to twice rated value
// - source 5 scales to 1.2 rated voltage
// - analog outputs span 0 V to 10 V
// - analog out is gain times standard plus offset
// - per-terminal switching delay 0.0 to 3600.0 s
// - polarity digits: units, tens, ten-thousands
// - digit 0 closes when active, 1 opens
`timescale 1ns/1ps
`include "oft_map.vh"
module oft_output_terminal #(
   parameter TICK_CYC = `OFT_TICK_CYC
) (
   // clock and reset
   input  wire        i_ref_clk,
   input  wire        i_rst,
   // apb slave
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   input  wire [7:0]  i_paddr,
   input  wire [31:0] i_pwdata,
   output reg  [31:0] o_prdata,
   output reg         o_pready,
   output reg         o_pslverr,
   // internal status
   input  wire        i_timing_en,
   input  wire        i_run_time_reached,
   input  wire        i_ain1_over_upper,
   input  wire        i_ain1_under_lower,
   input  wire        i_load_lost,
   input  wire        i_reverse,
   input  wire [15:0] i_heatsink_temp,
   input  wire [15:0] i_temp_threshold,
   input  wire        i_at_low_limit,
   input  wire        i_stopped,
   input  wire        i_fault,
   input  wire        i_fault_keep_run,
   input  wire        i_run_time_over,
   // measured quantities, per-mille of their full scale
   input  wire [15:0] i_run_freq_pm,
   input  wire [15:0] i_set_freq_pm,
   input  wire [15:0] i_current_pm,
   input  wire [15:0] i_torque_pm,
   input  wire [15:0] i_power_pm,
   input  wire [15:0] i_voltage_pm,
   input  wire [15:0] i_abs_current_pm,
   input  wire [15:0] i_bus_voltage_pm,
   // terminals
   output reg         o_transistor_out,
   output reg         o_relay1_contacts,
   output reg         o_relay2_contacts,
   output reg         o_multiplex_terminal,
   output reg  [11:0] o_analog_out1,
   output reg  [11:0] o_analog_out2
);
   reg  [15:0] mux_mode_r;
   reg  [15:0] psrc_r;
   reg  [15:0] a1src_r;
   reg  [15:0] a2src_r;
   reg  [15:0] fmax_r;
   reg  [15:0] a1ofs_r;
   reg  [15:0] a1gain_r;
   reg  [15:0] a2ofs_r;
   reg  [15:0] a2gain_r;
   reg  [15:0] pol_r;
   reg  [15:0] dly_r [0:3];
   reg  [23:0] fsel_r;
   wire [3:0]  act;
   reg  [3:0]  tgt_r, out_state_r;
   reg  [15:0] tmr_r [0:3];
   reg  [23:0] tick_cnt_r;
   reg         tick_r;
   wire        wr_en = i_psel & i_penable & i_pwrite;
   wire        rd_en = i_psel & i_penable & ~i_pwrite;
   reg         hit;
   reg  [31:0] rd_val;
   // first access edge of a transfer; the answer follows one cycle later
   wire        acc_first = i_psel & i_penable & ~o_pready;
   // gain -10.00..+10.00, offset -100.0..+100.0 percent; others refused
   wire signed [15:0] wr_s = i_pwdata[15:0];
   wire        gain_ok = (wr_s <= $signed(`OFT_GAIN_LIM)) && (wr_s >= -$signed(`OFT_GAIN_LIM));
   wire        ofs_ok = (wr_s <= $signed(`OFT_OFS_LIM)) && (wr_s >= -$signed(`OFT_OFS_LIM));
   // terminal runs as a switch only in mode 1
   wire        mux_pulse = (mux_mode_r == 16'h0);

   // function evaluation per terminal, fsel 6 bits per terminal
   function fn_eval;
      input [5:0] code;
      begin
         case (code)
            `OFT_FN_TIMING:    fn_eval = i_timing_en & i_run_time_reached;
            `OFT_FN_AIN_LIM:   fn_eval = i_ain1_over_upper | i_ain1_under_lower;
            `OFT_FN_LOAD_LOST: fn_eval = i_load_lost;
            `OFT_FN_REVERSE:   fn_eval = i_reverse & ~i_stopped;
            `OFT_FN_TEMP:      fn_eval = i_heatsink_temp >= i_temp_threshold;
            `OFT_FN_LOW_LIM:   fn_eval = i_at_low_limit | i_stopped;
            `OFT_FN_WARN:      fn_eval = i_fault & i_fault_keep_run;
            `OFT_FN_RUNTIME:   fn_eval = i_run_time_over;
            default:           fn_eval = 1'b0;
         endcase
      end
   endfunction

   // source select to per-mille of span
   function [15:0] src_pm;
      input [15:0] s;
      begin
         case (s)
            16'h0000: src_pm = i_run_freq_pm;
            16'h0001: src_pm = i_set_freq_pm;
            16'h0002: src_pm = i_current_pm;
            16'h0003: src_pm = i_torque_pm;
            16'h0004: src_pm = i_power_pm;
            16'h0005: src_pm = i_voltage_pm;
            16'h000e: src_pm = i_abs_current_pm;
            16'h000f: src_pm = i_bus_voltage_pm;
            default:  src_pm = 16'h0000;
         endcase
         if (src_pm > `OFT_SPAN_FULL)
            src_pm = `OFT_SPAN_FULL;
      end
   endfunction

   // y = k*x + b, x and b in per-mille of 10 V, k in hundredths
   function [11:0] ao_calc;
      input [15:0] x;
      input [15:0] k;
      input [15:0] b;
      reg signed [47:0] y;
      reg        [27:0] t;
      begin
         y = ($signed({32'h0, x}) * $signed({{32{k[15]}}, k})) / 100
             + $signed({{32{b[15]}}, b});
         if (y < 0)
            y = 0;
         if (y > $signed({32'h0, `OFT_SPAN_FULL}))
            y = {32'h0, `OFT_SPAN_FULL};
         t = y[27:0] * 28'd4095 / 28'd1000;
         ao_calc = t[11:0];
      end
   endfunction

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_fn
         assign act[g] = fn_eval(fsel_r[g*6 +: 6]);
      end
   endgenerate

   // tick of 0.1 s for the delay timers
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         tick_cnt_r <= 24'h0;
         tick_r     <= 1'b0;
      end else if (tick_cnt_r == TICK_CYC - 1) begin
         tick_cnt_r <= 24'h0;
         tick_r     <= 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 24'h1;
         tick_r     <= 1'b0;
      end
   end

   // delay per terminal, restarts when state changes again
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_dly
         always @(posedge i_ref_clk) begin
            if (i_rst) begin
               tgt_r[g]       <= 1'b0;
               out_state_r[g] <= 1'b0;
               tmr_r[g]       <= 16'h0;
            end else if (act[g] != tgt_r[g]) begin
               tgt_r[g] <= act[g];
               tmr_r[g] <= 16'h0;
               if (dly_r[g] == 16'h0)
                  out_state_r[g] <= act[g];
            end else if (out_state_r[g] != tgt_r[g]) begin
               if (tmr_r[g] >= dly_r[g])
                  out_state_r[g] <= tgt_r[g];
               else if (tick_r)
                  tmr_r[g] <= tmr_r[g] + 16'h1;
            end
         end
      end
   endgenerate

   // pulse output: phase accumulator, step = f * 2^32 / clock
   // f in 10 Hz units, so step = f * 4294.967; wide product avoids wrap
   reg  [31:0] phase_r;
   reg  [15:0] pfreq_r;
   wire [31:0] pscale = {16'h0, src_pm(psrc_r)} * {16'h0, fmax_r - `OFT_FMAX_MIN};
   wire [31:0] pquot = pscale / 32'd1000;
   wire [47:0] pf_mul = {32'h0, pfreq_r} * 48'd4294967;
   wire [47:0] pstep = pf_mul / 48'd1000;
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         pfreq_r <= `OFT_FMAX_MIN;
         phase_r <= 32'h0;
      end else begin
         pfreq_r <= pquot[15:0] + `OFT_FMAX_MIN;
         phase_r <= phase_r + pstep[31:0];
      end
   end

   // polarity digit per terminal, relay2 digit is reserved
   wire [3:0] pol_inv;
   assign pol_inv[0] = ((pol_r % 16'd10) == 16'd1);
   assign pol_inv[1] = (((pol_r / 16'd10) % 16'd10) == 16'd1);
   assign pol_inv[2] = 1'b0;
   assign pol_inv[3] = (((pol_r / 16'd10000) % 16'd10) == 16'd1);

   // terminals with polarity
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_transistor_out     <= 1'b0;
         o_relay1_contacts    <= 1'b0;
         o_relay2_contacts    <= 1'b0;
         o_multiplex_terminal <= 1'b0;
         o_analog_out1        <= 12'h000;
         o_analog_out2        <= 12'h000;
      end else begin
         o_transistor_out  <= out_state_r[0] ^ pol_inv[0];
         o_relay1_contacts <= out_state_r[1] ^ pol_inv[1];
         o_relay2_contacts <= out_state_r[2] ^ pol_inv[2];
         if (mux_pulse)
            o_multiplex_terminal <= phase_r[31];
         else
            o_multiplex_terminal <= out_state_r[3] ^ pol_inv[3];
         o_analog_out1 <= ao_calc(src_pm(a1src_r), a1gain_r, a1ofs_r);
         o_analog_out2 <= ao_calc(src_pm(a2src_r), a2gain_r, a2ofs_r);
      end
   end

   // apb read mux
   always @* begin
      hit    = 1'b1;
      rd_val = 32'h0;
      case (i_paddr)
         `OFT_A_MUX_MODE:   rd_val = {16'h0, mux_mode_r};
         `OFT_A_PULSE_SRC:  rd_val = {16'h0, psrc_r};
         `OFT_A_AO1_SRC:    rd_val = {16'h0, a1src_r};
         `OFT_A_AO2_SRC:    rd_val = {16'h0, a2src_r};
         `OFT_A_PULSE_FMAX: rd_val = {16'h0, fmax_r};
         `OFT_A_AO1_OFS:    rd_val = {16'h0, a1ofs_r};
         `OFT_A_AO1_GAIN:   rd_val = {16'h0, a1gain_r};
         `OFT_A_AO2_OFS:    rd_val = {16'h0, a2ofs_r};
         `OFT_A_AO2_GAIN:   rd_val = {16'h0, a2gain_r};
         `OFT_A_TR_DLY:     rd_val = {16'h0, dly_r[0]};
         `OFT_A_RL1_DLY:    rd_val = {16'h0, dly_r[1]};
         `OFT_A_RL2_DLY:    rd_val = {16'h0, dly_r[2]};
         `OFT_A_RSVD_DLY:   rd_val = 32'h0;
         `OFT_A_MSW_DLY:    rd_val = {16'h0, dly_r[3]};
         `OFT_A_POLARITY:   rd_val = {16'h0, pol_r};
         `OFT_A_FUNC_SEL:   rd_val = {8'h0, fsel_r};
         `OFT_A_STATUS:     rd_val = {24'h0, out_state_r, tgt_r};
         default:           hit = 1'b0;
      endcase
   end

   // apb register writes, out-of-range mode, maximum, gain, offset and delay values refused; sources and polarity unchecked
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         mux_mode_r <= 16'h0;
         psrc_r     <= 16'h0;
         a1src_r    <= 16'h0;
         a2src_r    <= `OFT_RST_AO2_SRC;
         fmax_r     <= `OFT_RST_FMAX;
         a1ofs_r    <= 16'h0;
         a1gain_r   <= `OFT_RST_GAIN;
         a2ofs_r    <= 16'h0;
         a2gain_r   <= `OFT_RST_GAIN;
         dly_r[0]   <= 16'h0;
         dly_r[1]   <= 16'h0;
         dly_r[2]   <= 16'h0;
         dly_r[3]   <= 16'h0;
         pol_r      <= 16'h0;
         fsel_r     <= 24'h0;
      end else begin
         if (wr_en & ~o_pready) begin
            case (i_paddr)
               `OFT_A_MUX_MODE:   if (i_pwdata[15:0] <= 16'h1)
                                     mux_mode_r <= i_pwdata[15:0];
               `OFT_A_PULSE_SRC:  psrc_r <= i_pwdata[15:0];
               `OFT_A_AO1_SRC:    a1src_r <= i_pwdata[15:0];
               `OFT_A_AO2_SRC:    a2src_r <= i_pwdata[15:0];
               `OFT_A_PULSE_FMAX: if (i_pwdata[15:0] >= `OFT_FMAX_MIN &&
                                      i_pwdata[15:0] <= `OFT_FMAX_MAX)
                                     fmax_r <= i_pwdata[15:0];
               `OFT_A_AO1_OFS:    if (ofs_ok)
                                     a1ofs_r <= i_pwdata[15:0];
               `OFT_A_AO1_GAIN:   if (gain_ok)
                                     a1gain_r <= i_pwdata[15:0];
               `OFT_A_AO2_OFS:    if (ofs_ok)
                                     a2ofs_r <= i_pwdata[15:0];
               `OFT_A_AO2_GAIN:   if (gain_ok)
                                     a2gain_r <= i_pwdata[15:0];
               `OFT_A_TR_DLY:     if (i_pwdata[15:0] <= `OFT_DLY_MAX)
                                     dly_r[0] <= i_pwdata[15:0];
               `OFT_A_RL1_DLY:    if (i_pwdata[15:0] <= `OFT_DLY_MAX)
                                     dly_r[1] <= i_pwdata[15:0];
               `OFT_A_RL2_DLY:    if (i_pwdata[15:0] <= `OFT_DLY_MAX)
                                     dly_r[2] <= i_pwdata[15:0];
               `OFT_A_MSW_DLY:    if (i_pwdata[15:0] <= `OFT_DLY_MAX)
                                     dly_r[3] <= i_pwdata[15:0];
               `OFT_A_POLARITY:   pol_r <= i_pwdata[15:0];
               `OFT_A_FUNC_SEL:   fsel_r <= i_pwdata[23:0];
               default:           fsel_r <= fsel_r;
            endcase
         end
      end
   end

   // apb answer: one wait state, every answer field stands one cycle
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_prdata  <= 32'h0;
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
      end else begin
         o_pready  <= acc_first;
         o_pslverr <= acc_first & ~hit;
         o_prdata  <= (rd_en & ~o_pready) ? rd_val : 32'h0;
      end
   end
endmodule // oft_output_terminal

// ### tb_top.sv
// self-checking bench: apb tasks, status stimulus, terminal, pulse and analog checks
// assumes oft_chk bound into the design and oft_meter on the multiplexed terminal
`timescale 1ns/1ps
`include "oft_map.vh"
module tb_top;
   localparam TICK = 4;
   localparam [47:0] CODES = {6'h28, 6'h26, 6'h25, 6'h23, 6'h21, 6'h20, 6'h1f, 6'h1e};
   localparam [63:0] SRCS = {8'h0f, 8'h0e, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01, 8'h00};
   reg         clk = 1'b0;
   reg         rst = 1'b1;
   reg         psel = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite = 1'b0;
   reg  [7:0]  paddr = 8'h00;
   reg  [31:0] pwdata = 32'h0;
   reg  [7:0]  cond = 8'h00;
   reg  [15:0] q = 16'h0000;
   reg         clr = 1'b1;
   reg  [31:0] rd;
   reg         err;
   reg  [5:0]  c;
   wire [31:0] prdata;
   wire        pready, pslverr, tr, rl1, rl2, mux;
   wire [11:0] ao1, ao2;
   wire [15:0] edges;
   integer     err_count = 0;
   integer     tests_run = 0;
   integer     i;
   always #50 clk = ~clk;
   oft_output_terminal #(.TICK_CYC(TICK)) DUT (
      .i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_timing_en(cond[0]), .i_run_time_reached(cond[0]),
      .i_ain1_over_upper(cond[1]), .i_ain1_under_lower(cond[1]), .i_load_lost(cond[2]),
      .i_reverse(cond[3]), .i_heatsink_temp({11'h0, cond[4], 4'h0}),
      .i_temp_threshold(16'h0010), .i_at_low_limit(cond[5]), .i_stopped(cond[5]),
      .i_fault(cond[6]), .i_fault_keep_run(cond[6]), .i_run_time_over(cond[7]),
      .i_run_freq_pm(q), .i_set_freq_pm(q), .i_current_pm(q), .i_torque_pm(q),
      .i_power_pm(q), .i_voltage_pm(q), .i_abs_current_pm(q), .i_bus_voltage_pm(q),
      .o_transistor_out(tr), .o_relay1_contacts(rl1), .o_relay2_contacts(rl2),
      .o_multiplex_terminal(mux), .o_analog_out1(ao1), .o_analog_out2(ao2));
   oft_meter u_meter (.i_ref_clk(clk), .i_clr(clr), .i_terminal(mux), .o_edges(edges));
   task stop_test;
      begin
         $display("checks %0d mismatches %0d", tests_run, err_count);
         if (err_count == 0 && tests_run > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] lo, input [31:0] hi);
      begin
         tests_run = tests_run + 1;
         if ((got >= lo && got <= hi) !== 1'b1) begin
            err_count = err_count + 1;
            $display("FAIL %0t got %h want %h..%h", $time, got, lo, hi);
         end
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge clk);
   endtask
   // one transfer; waits out the answer, never a fixed count
   task apb(input w, input [7:0] a, input [31:0] d);
      integer n;
      begin
         n = 0;
         @(posedge clk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clk);
         penable <= 1'b1;
         @(posedge clk);
         while (pready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n = n + 1;
         end
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         if (n == 20) begin
            err_count = err_count + 1;
            $display("FAIL %0t no answer", $time);
            stop_test;
         end
      end
   endtask
   task rchk(input [7:0] a, input [31:0] e);
      begin
         apb(1'b0, a, 32'h0);
         chk(rd, e, e);
      end
   endtask
   task pulse(input [31:0] lo, input [31:0] hi);
      begin
         clr <= 1'b1;
         cyc(2);
         clr <= 1'b0;
         cyc(1000);
         chk(edges, lo, hi);
      end
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      clr <= 1'b0;
      rchk(`OFT_A_MUX_MODE, 32'h0);
      rchk(`OFT_A_AO2_SRC, 32'h1);
      rchk(`OFT_A_PULSE_FMAX, 32'h1388);
      rchk(`OFT_A_AO1_GAIN, 32'h64);
      rchk(`OFT_A_RSVD_DLY, 32'h0);
      apb(1'b1, `OFT_A_MUX_MODE, 32'h2);
      rchk(`OFT_A_MUX_MODE, 32'h0);
      apb(1'b1, `OFT_A_PULSE_FMAX, 32'h2711);
      rchk(`OFT_A_PULSE_FMAX, 32'h1388);
      apb(1'b1, `OFT_A_AO1_GAIN, 32'h3e9);
      rchk(`OFT_A_AO1_GAIN, 32'h64);
      apb(1'b0, 8'h44, 32'h0);
      chk(err, 32'h1, 32'h1);
      $display("registers done");
      for (i = 0; i < 8; i = i + 1) begin
         c = CODES[i*6 +: 6];
         apb(1'b1, `OFT_A_FUNC_SEL, {8'h00, c, c, c, c});
         cond <= 8'h01 << i;
         cyc(10);
         chk({tr, rl1, rl2}, 32'h7, 32'h7);
         cond <= 8'h00;
         cyc(10);
         chk({tr, rl1, rl2}, 32'h0, 32'h0);
      end
      $display("functions done");
      apb(1'b1, `OFT_A_MUX_MODE, 32'h1);
      apb(1'b1, `OFT_A_POLARITY, 32'h271b);
      cyc(10);
      chk({tr, rl1, rl2, mux}, 32'hd, 32'hd);
      cond <= 8'h80;
      cyc(10);
      chk({tr, rl1, rl2, mux}, 32'h2, 32'h2);
      apb(1'b1, `OFT_A_POLARITY, 32'h0);
      cyc(10);
      chk({tr, rl1, rl2, mux}, 32'hf, 32'hf);
      $display("polarity done");
      apb(1'b1, `OFT_A_TR_DLY, 32'h8ca1);
      apb(1'b1, `OFT_A_TR_DLY, 32'h5);
      rchk(`OFT_A_TR_DLY, 32'h5);
      cond <= 8'h00;
      cyc(10);
      chk(tr, 32'h1, 32'h1);
      cond <= 8'h80;
      cyc(10);
      cond <= 8'h00;
      cyc(10);
      chk(tr, 32'h1, 32'h1);
      cyc(20);
      chk(tr, 32'h0, 32'h0);
      $display("delay done");
      apb(1'b1, `OFT_A_MUX_MODE, 32'h0);
      apb(1'b1, `OFT_A_PULSE_FMAX, 32'h2710);
      q <= 16'h03e8;
      pulse(32'h9, 32'hb);
      apb(1'b1, `OFT_A_PULSE_FMAX, 32'h1388);
      pulse(32'h4, 32'h6);
      $display("pulse done");
      q <= 16'h01f4;
      for (i = 0; i < 8; i = i + 1) begin
         apb(1'b1, `OFT_A_AO1_SRC, {24'h0, SRCS[i*8 +: 8]});
         cyc(5);
         chk(ao1, 32'h7fe, 32'h801);
      end
      chk(ao2, 32'h7fe, 32'h801);
      apb(1'b1, `OFT_A_AO1_GAIN, 32'hff9c);
      apb(1'b1, `OFT_A_AO1_OFS, 32'h3e8);
      cyc(5);
      chk(ao1, 32'h7fe, 32'h801);
      $display("analog done");
      stop_test;
   end
endmodule // tb_top
